// *** hdl/ssx_pkg.sv ***
// Package for the execute unit of the subtract/swap/xor/sleep group.
// Assumes a single core clock domain; shared by all design files.
`default_nettype none
package ssx_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W = 4;
    localparam int WDT_W = 8;
    localparam int PRE_W = 8;
    localparam logic [WDT_W-1:0] WDT_CLEAR = 8'h00;
    localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;
    localparam logic SLEEP_ENTRY_SET_VAL = 1'b0;
    localparam logic WATCHDOG_EXPIRY_SET_VAL = 1'b1;
    // AHB-Lite register map (byte addresses)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_OPERAND = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    localparam logic [7:0] OFS_WDT = 8'h14;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // Status field positions
    localparam int ST_C = 0;
    localparam int ST_HALF_CARRY = 1;
    localparam int ST_Z = 2;
    localparam int ST_SLEEP_ENTRY = 3;
    localparam int ST_WATCHDOG_EXPIRY = 4;
    localparam int ST_SLEEP = 5;
    // Command field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST = 4;
    localparam int CMD_ADDR_LSB = 8;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_LITERAL_MINUS_ACC = 3'h1,
        OP_REG_MINUS_ACC = 3'h2,
        OP_NIBBLE_EXCHANGE = 3'h3,
        OP_LITERAL_XOR = 3'h4,
        OP_REGISTER_XOR = 3'h5,
        OP_SLEEP = 3'h6
    } ssx_op_t;
endpackage
`default_nettype wire

// *** hdl/ssx_alu.sv ***
// Combinational ALU for subtract, nibble swap and exclusive-OR.
// Assumes operands are stable within the cycle; no state inside.
`default_nettype none
module ssx_alu #(
    parameter int W = ssx_pkg::DATA_W
) (
    // Operation and operands
    input wire ssx_pkg::ssx_op_t op,
    input wire logic [W-1:0] acc,
    input wire logic [W-1:0] lit,
    input wire logic [W-1:0] regVal,
    // Result and flags
    output logic [W-1:0] result,
    output logic carry,
    output logic halfCarry,
    output logic zero
);
    function automatic logic [W:0] sub_full(input logic [W-1:0] a, input logic [W-1:0] b);
        sub_full = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, 1'b1};
    endfunction

    function automatic logic half_no_borrow(input logic [W-1:0] a, input logic [W-1:0] b);
        logic [ssx_pkg::NIB_W:0] s;
        s = {1'b0, a[ssx_pkg::NIB_W-1:0]} + {1'b0, ~b[ssx_pkg::NIB_W-1:0]} + 5'h01;
        half_no_borrow = s[ssx_pkg::NIB_W];
    endfunction

    logic [W-1:0] subA;
    logic [W:0] diff;

    always_comb begin
        subA = (op == ssx_pkg::OP_LITERAL_MINUS_ACC) ? lit : regVal;
        diff = sub_full(subA, acc);
        result = ssx_pkg::ZERO_BYTE;
        carry = 1'b0;
        halfCarry = 1'b0;
        unique case (op)
            ssx_pkg::OP_LITERAL_MINUS_ACC, ssx_pkg::OP_REG_MINUS_ACC: begin
                result = diff[W-1:0];
                carry = diff[W];
                halfCarry = half_no_borrow(subA, acc);
            end
            ssx_pkg::OP_NIBBLE_EXCHANGE: begin
                result = {regVal[ssx_pkg::NIB_W-1:0], regVal[W-1:ssx_pkg::NIB_W]};
            end
            ssx_pkg::OP_LITERAL_XOR: result = acc ^ lit;
            ssx_pkg::OP_REGISTER_XOR: result = acc ^ regVal;
            default: result = ssx_pkg::ZERO_BYTE;
        endcase
        zero = (result == ssx_pkg::ZERO_BYTE);
    end
endmodule
`default_nettype wire

// *** hdl/ssx_exec.sv ***
// Execute stage for subtract, swap, xor and sleep, with AHB-Lite access.
// Assumes one clock (mclk, 40 MHz); register file lives outside the block.
`default_nettype none
// Operation
// - Sleep clears watchdog counter and prescaler
// - Sleep clears sleep flag, sets expiry flag
// - Sleep then halts the oscillator
// - Literal minus accumulator into accumulator, flags
// - Register minus accumulator, seven-bit address, flags
// - Destination bit picks accumulator or register
// - Nibble swap, no flags change
// - Literal xor accumulator, zero flag only
// - Register xor accumulator, routed, zero only
module ssx_exec #(
    parameter int W = ssx_pkg::DATA_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register file port
    output logic [ssx_pkg::ADDR_W-1:0] regAddr,
    input wire logic [W-1:0] regRdata,
    output logic regWe,
    output logic [W-1:0] regWdata,
    // Sleep and watchdog control
    output logic wdtClear,
    output logic oscHalt,
    output logic [ssx_pkg::WDT_W-1:0] wdtCount,
    output logic [ssx_pkg::PRE_W-1:0] wdtPrescale
);
    // Address phase capture
    logic wrPend_q, wrPend_d;
    logic [7:0] addrPh_q, addrPh_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic addrTaken;

    // Architectural state
    logic [W-1:0] acc_q, acc_d, operand_q, operand_d, result_q, result_d;
    logic [ssx_pkg::ADDR_W-1:0] regAddr_q, regAddr_d;
    logic carry_q, carry_d, halfCarry_q, halfCarry_d, zero_q, zero_d;
    logic sleepEntryFlag_q, sleepEntryFlag_d, watchdogExpiryFlag_q, watchdogExpiryFlag_d;
    logic oscHalt_q, oscHalt_d, regWe_q, regWe_d, wdtClear_q, wdtClear_d;
    logic [ssx_pkg::WDT_W-1:0] wdt_q, wdt_d;
    logic [ssx_pkg::PRE_W-1:0] pre_q, pre_d;

    // Command decode
    ssx_pkg::ssx_op_t op;
    logic dest, execGo;
    logic [W-1:0] aluRes;
    logic aluC, aluHc, aluZ;

    assign addrTaken = hsel && hready && (htrans == ssx_pkg::HTRANS_NONSEQ);
    assign execGo = wrPend_q && (addrPh_q == ssx_pkg::OFS_CMD);
    assign op = ssx_pkg::ssx_op_t'(hwdata[ssx_pkg::CMD_OP_LSB +: 3]);
    assign dest = hwdata[ssx_pkg::CMD_DEST];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign regAddr = execGo ? hwdata[ssx_pkg::CMD_ADDR_LSB +: ssx_pkg::ADDR_W] : regAddr_q;
    assign regWe = regWe_q;
    assign regWdata = result_q;
    assign wdtClear = wdtClear_q;
    assign oscHalt = oscHalt_q;
    assign wdtCount = wdt_q;
    assign wdtPrescale = pre_q;

    ssx_alu #(.W(W)) uAlu (
        .op(op),
        .acc(acc_q),
        .lit(operand_q),
        .regVal(regRdata),
        .result(aluRes),
        .carry(aluC),
        .halfCarry(aluHc),
        .zero(aluZ)
    );

    always_comb begin
        wrPend_d = addrTaken && hwrite;
        addrPh_d = addrTaken ? haddr[7:0] : addrPh_q;
        // Loaded in the address phase from next state, so it stands in the data phase
        hrdata_d = hrdata_q;
        if (addrTaken && !hwrite) begin
            unique case (haddr[7:0])
                ssx_pkg::OFS_OPERAND: hrdata_d = {24'h0, operand_d};
                ssx_pkg::OFS_ACC: hrdata_d = {24'h0, acc_d};
                ssx_pkg::OFS_STATUS: hrdata_d = {26'h0, oscHalt_d, watchdogExpiryFlag_d,
                    sleepEntryFlag_d, zero_d, halfCarry_d, carry_d};
                ssx_pkg::OFS_RESULT: hrdata_d = {24'h0, result_d};
                ssx_pkg::OFS_WDT: hrdata_d = {16'h0, pre_d, wdt_d};
                default: hrdata_d = 32'h0;
            endcase
        end
    end

    always_comb begin
        acc_d = acc_q;
        operand_d = operand_q;
        result_d = result_q;
        regAddr_d = regAddr_q;
        carry_d = carry_q;
        halfCarry_d = halfCarry_q;
        zero_d = zero_q;
        sleepEntryFlag_d = sleepEntryFlag_q;
        watchdogExpiryFlag_d = watchdogExpiryFlag_q;
        oscHalt_d = oscHalt_q;
        regWe_d = 1'b0;
        wdtClear_d = 1'b0;
        wdt_d = oscHalt_q ? wdt_q : wdt_q + 8'h01;
        pre_d = oscHalt_q ? pre_q : pre_q + 8'h01;
        if (wrPend_q && addrPh_q == ssx_pkg::OFS_OPERAND) operand_d = hwdata[W-1:0];
        if (wrPend_q && addrPh_q == ssx_pkg::OFS_ACC) acc_d = hwdata[W-1:0];
        if (wrPend_q && addrPh_q == ssx_pkg::OFS_STATUS) oscHalt_d = hwdata[ssx_pkg::ST_SLEEP];
        if (execGo && !oscHalt_q) begin
            regAddr_d = hwdata[ssx_pkg::CMD_ADDR_LSB +: ssx_pkg::ADDR_W];
            unique case (op)
                ssx_pkg::OP_LITERAL_MINUS_ACC, ssx_pkg::OP_REG_MINUS_ACC: begin
                    carry_d = aluC;
                    halfCarry_d = aluHc;
                    zero_d = aluZ;
                end
                ssx_pkg::OP_LITERAL_XOR, ssx_pkg::OP_REGISTER_XOR: zero_d = aluZ;
                default: zero_d = zero_q;
            endcase
            unique case (op)
                ssx_pkg::OP_LITERAL_MINUS_ACC, ssx_pkg::OP_LITERAL_XOR: begin
                    acc_d = aluRes;
                    result_d = aluRes;
                end
                ssx_pkg::OP_REG_MINUS_ACC, ssx_pkg::OP_NIBBLE_EXCHANGE, ssx_pkg::OP_REGISTER_XOR: begin
                    result_d = aluRes;
                    if (dest == ssx_pkg::DEST_ACC) acc_d = aluRes;
                    else regWe_d = 1'b1;
                end
                ssx_pkg::OP_SLEEP: begin
                    wdt_d = ssx_pkg::WDT_CLEAR;
                    pre_d = ssx_pkg::PRE_CLEAR;
                    wdtClear_d = 1'b1;
                    sleepEntryFlag_d = ssx_pkg::SLEEP_ENTRY_SET_VAL;
                    watchdogExpiryFlag_d = ssx_pkg::WATCHDOG_EXPIRY_SET_VAL;
                    oscHalt_d = 1'b1;
                end
                default: result_d = result_q;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrPend_q <= 1'b0;
            addrPh_q <= 8'h00;
            hrdata_q <= 32'h0;
            acc_q <= ssx_pkg::ACC_RESET;
            operand_q <= ssx_pkg::ZERO_BYTE;
            result_q <= ssx_pkg::ZERO_BYTE;
            regAddr_q <= 7'h00;
            carry_q <= 1'b0;
            halfCarry_q <= 1'b0;
            zero_q <= 1'b0;
            sleepEntryFlag_q <= 1'b1;
            watchdogExpiryFlag_q <= 1'b1;
            oscHalt_q <= 1'b0;
            regWe_q <= 1'b0;
            wdtClear_q <= 1'b0;
            wdt_q <= ssx_pkg::WDT_CLEAR;
            pre_q <= ssx_pkg::PRE_CLEAR;
        end else if (clkEn) begin
            wrPend_q <= wrPend_d;
            addrPh_q <= addrPh_d;
            hrdata_q <= hrdata_d;
            acc_q <= acc_d;
            operand_q <= operand_d;
            result_q <= result_d;
            regAddr_q <= regAddr_d;
            carry_q <= carry_d;
            halfCarry_q <= halfCarry_d;
            zero_q <= zero_d;
            sleepEntryFlag_q <= sleepEntryFlag_d;
            watchdogExpiryFlag_q <= watchdogExpiryFlag_d;
            oscHalt_q <= oscHalt_d;
            regWe_q <= regWe_d;
            wdtClear_q <= wdtClear_d;
            wdt_q <= wdt_d;
            pre_q <= pre_d;
        end
    end

    // Checks
    logic sleepGo, subGo, xorGo, swapGo;
    assign sleepGo = clkEn && execGo && !oscHalt_q && op == ssx_pkg::OP_SLEEP;
    assign subGo = clkEn && execGo && !oscHalt_q &&
        (op == ssx_pkg::OP_LITERAL_MINUS_ACC || op == ssx_pkg::OP_REG_MINUS_ACC);
    assign xorGo = clkEn && execGo && !oscHalt_q &&
        (op == ssx_pkg::OP_LITERAL_XOR || op == ssx_pkg::OP_REGISTER_XOR);
    assign swapGo = clkEn && execGo && !oscHalt_q && op == ssx_pkg::OP_NIBBLE_EXCHANGE;

    sequence s_sleepIssued;
        sleepGo;
    endsequence

    a_sleep_wdt_clear: assert property (@(posedge mclk) disable iff (!rstn)
        s_sleepIssued |=> (wdt_q == ssx_pkg::WDT_CLEAR && pre_q == ssx_pkg::PRE_CLEAR && wdtClear_q))
        else $error("sleep did not clear watchdog");
    a_sleep_status_bits: assert property (@(posedge mclk) disable iff (!rstn)
        s_sleepIssued |=> (!sleepEntryFlag_q && watchdogExpiryFlag_q && $stable(carry_q) && $stable(zero_q)))
        else $error("sleep status bits wrong");
    a_sleep_osc_halt: assert property (@(posedge mclk) disable iff (!rstn)
        s_sleepIssued |=> oscHalt_q)
        else $error("oscillator not halted after sleep");
    a_sub_literal_acc: assert property (@(posedge mclk) disable iff (!rstn)
        (subGo && op == ssx_pkg::OP_LITERAL_MINUS_ACC) |=>
        acc_q == W'($past(operand_q) - $past(acc_q)))
        else $error("literal minus accumulator wrong");
    a_sub_reg_result: assert property (@(posedge mclk) disable iff (!rstn)
        (subGo && op == ssx_pkg::OP_REG_MINUS_ACC) |=> result_q == W'($past(regRdata) - $past(acc_q)))
        else $error("register minus accumulator wrong");
    a_dest_reg_write: assert property (@(posedge mclk) disable iff (!rstn)
        (execGo && clkEn && !oscHalt_q && op == ssx_pkg::OP_REGISTER_XOR && dest == ssx_pkg::DEST_REG)
        |=> (regWe && $stable(acc_q)))
        else $error("destination select not honoured");
    a_swap_nibbles: assert property (@(posedge mclk) disable iff (!rstn)
        swapGo |=> (result_q == {$past(regRdata[3:0]), $past(regRdata[7:4])} && $stable(zero_q)
        && $stable(carry_q)))
        else $error("nibble swap wrong");
    a_xor_flags_only: assert property (@(posedge mclk) disable iff (!rstn)
        xorGo |=> ($stable(carry_q) && $stable(halfCarry_q)))
        else $error("xor touched carry flags");
    a_sub_carry_borrow: assert property (@(posedge mclk) disable iff (!rstn)
        (subGo && op == ssx_pkg::OP_LITERAL_MINUS_ACC) |=> carry_q == ($past(operand_q) >= $past(acc_q)))
        else $error("carry does not mean no borrow");
    a_zero_flag_result: assert property (@(posedge mclk) disable iff (!rstn)
        (subGo || xorGo) |=> zero_q == (result_q == ssx_pkg::ZERO_BYTE))
        else $error("zero flag mismatch");
endmodule
`default_nettype wire

// *** tb/sub_swap_xor_sleep_exec_bench.sv ***
// Self-checking bench for the subtract/swap/xor/sleep execute unit.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready; bench models the register file.
`default_nettype none
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin nFail++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module sub_swap_xor_sleep_exec_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rstn, clkEn, hsel, hwrite, hready, hreadyout, hresp, regWe, wdtClear, oscHalt, clrSeen;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, flE;
    logic [6:0] regAddr;
    logic [7:0] regRdata, regWdata, wdtCount, wdtPrescale, accE, resE, rOld, saved;
    logic [7:0] regFile [0:127];
    int nFail, nChecks;
    // Fields: op, dest, addr, literal, acc; order leaves flags nonzero only before the first swap and the second xor
    localparam logic [31:0] VEC [0:10] = '{32'h10005555, 32'h10000001, 32'h10001001, 32'h30050000,
        32'h117f0033, 32'h317f0000, 32'h210000ff, 32'h4000a5a5, 32'h40000ff0, 32'h507f0012, 32'h51120081};
    ssx_exec u_ssx_exec (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .regAddr(regAddr), .regRdata(regRdata),
        .regWe(regWe), .regWdata(regWdata), .wdtClear(wdtClear), .oscHalt(oscHalt),
        .wdtCount(wdtCount), .wdtPrescale(wdtPrescale));
    assign hready = hreadyout;
    assign regRdata = regFile[regAddr];
    always #12.5ns mclk = ~mclk;
    always @(posedge mclk) begin
        if (regWe === 1'b1) regFile[regAddr] <= regWdata;
        if (wdtClear === 1'b1) clrSeen <= 1'b1;
    end
    task automatic ahbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= ssx_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic ahbWrite(input logic [7:0] a, input logic [31:0] d);
        ahbXfer(1'b1, a, d);
    endtask
    task automatic ahbRead(input logic [7:0] a);
        ahbXfer(1'b0, a, 32'h0);
    endtask
    task automatic runOp(input logic [31:0] v);
        logic [2:0] op;
        logic dest;
        logic [6:0] ad;
        logic [7:0] k, a, src;
        logic [8:0] d;
        logic [4:0] h;
        op = v[30:28];
        dest = v[24];
        ad = v[22:16];
        k = v[15:8];
        a = v[7:0];
        rOld = regFile[ad];
        ahbWrite(ssx_pkg::OFS_OPERAND, {24'h0, k});
        ahbWrite(ssx_pkg::OFS_ACC, {24'h0, a});
        ahbWrite(ssx_pkg::OFS_CMD, {17'h0, ad, 3'h0, dest, 1'b0, op});
        src = (op == ssx_pkg::OP_LITERAL_MINUS_ACC) ? k : rOld;
        case (op)
            3'h1, 3'h2: begin
                d = {1'b0, src} - {1'b0, a};
                h = {1'b0, src[3:0]} - {1'b0, a[3:0]};
                resE = d[7:0];
                flE = {resE == 8'h00, ~h[4], ~d[8]};
            end
            3'h3: resE = {rOld[3:0], rOld[7:4]};
            3'h4: begin
                resE = a ^ k;
                flE[2] = resE == 8'h00;
            end
            default: begin
                resE = a ^ rOld;
                flE[2] = resE == 8'h00;
            end
        endcase
        accE = (op == 3'h1 || op == 3'h4 || !dest) ? resE : a;
        repeat (2) @(posedge mclk);
        ahbRead(ssx_pkg::OFS_ACC);
        `CHK("acc", accE, rd[7:0])
        ahbRead(ssx_pkg::OFS_RESULT);
        `CHK("result", resE, rd[7:0])
        ahbRead(ssx_pkg::OFS_STATUS);
        `CHK("flags", flE, rd[2:0])
        `CHK("regfile", (dest && op != 3'h1 && op != 3'h4) ? resE : rOld, regFile[ad])
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 25ns);
        nFail++;
        printVerdict();
    end
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        clkEn = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        clrSeen = 1'b0;
        flE = 3'h0;
        for (int i = 0; i < 128; i++) regFile[i] = 8'(i * 37 + 19);
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        ahbRead(ssx_pkg::OFS_STATUS);
        `CHK("statusReset", 6'h18, rd[5:0])
        ahbRead(8'h3c);
        `CHK("unmapped", 32'h0, rd)
        foreach (VEC[i]) runOp(VEC[i]);
        @(posedge mclk);
        clkEn <= 1'b0;
        @(posedge mclk);
        #1ns;
        saved = wdtCount;
        repeat (3) @(posedge mclk);
        #1ns;
        `CHK("frozen", saved, wdtCount)
        clkEn <= 1'b1;
        ahbWrite(ssx_pkg::OFS_CMD, {29'h0, 3'h6});
        repeat (2) @(posedge mclk);
        #1ns;
        `CHK("wdtClear", 1'b1, clrSeen)
        `CHK("oscHalt", 1'b1, oscHalt)
        repeat (4) @(posedge mclk);
        #1ns;
        `CHK("wdtCount", ssx_pkg::WDT_CLEAR, wdtCount)
        `CHK("wdtPrescale", ssx_pkg::PRE_CLEAR, wdtPrescale)
        ahbRead(ssx_pkg::OFS_STATUS);
        `CHK("sleepStatus", {3'h6, flE}, rd[5:0])
        // Literal minus acc would change acc if the halt were ignored
        ahbWrite(ssx_pkg::OFS_CMD, {29'h0, 3'h1});
        repeat (2) @(posedge mclk);
        ahbRead(ssx_pkg::OFS_ACC);
        `CHK("accHalted", accE, rd[7:0])
        ahbWrite(ssx_pkg::OFS_STATUS, 32'h0);
        repeat (2) @(posedge mclk);
        #1ns;
        `CHK("resumed", 1'b0, oscHalt)
        printVerdict();
    end
endmodule
`default_nettype wire
